// ### hdl/umtc_pkg.sv
// package for the usb master transfer control block
package umtc_pkg;
    localparam logic [11:0] CTRL_ADDR      = 12'h000; // control register
    localparam logic [11:0] WCOUNT_ADDR    = 12'h004; // write transfer length, words
    localparam logic [11:0] RCOUNT_ADDR    = 12'h008; // read transfer length, words
    localparam logic [11:0] STATUS_ADDR    = 12'h00c; // fifo level, output stage included
    localparam int          BIT_WRUN       = 0;
    localparam int          BIT_WSTOP      = 1;
    localparam int          BIT_WINIT      = 2;
    localparam int          BIT_RRUN       = 4;
    localparam int          BIT_RSTOP      = 5;
    localparam int          BIT_RINIT      = 6;
    localparam int          BIT_BURST      = 8;
    localparam int          DATA_W         = 32;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          LVL_W          = 5;
    localparam int          CNT_W          = 16;
    localparam logic [3:0]  INIT_CYCLES    = 4'h4; // init sequence length
    localparam logic [31:0] ZERO_WORD      = 32'h0;
endpackage : umtc_pkg

// ### hdl/umtc_fifo.sv
// fifo with valid/ready on both sides
`timescale 1ns/1ns
module umtc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,       // clock
    input  wire logic             rst,       // sync reset, high
    input  wire logic             ce,        // clock enable
    input  wire logic             flush,     // empties the fifo
    input  wire logic [WIDTH-1:0] in_data,   // fill data
    input  wire logic             in_valid,  // fill valid
    output logic                  in_ready,  // not full
    output logic      [WIDTH-1:0] out_data,  // head word
    output logic                  out_valid, // not empty
    input  wire logic             out_ready, // drain ready
    output logic      [AW:0]      level      // words held
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW-1:0]    next_wp;
    logic [AW-1:0]    next_rp;
    logic [AW:0]      next_level;
    logic             push;
    logic             pop;

    // full and empty come straight from the level count
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem[rp];
    assign push      = in_valid & (level != (AW+1)'(DEPTH));
    assign pop       = out_valid & out_ready;

    // pointer and level update
    always_comb
    begin
        next_wp    = push ? wp + 1'b1 : wp;
        next_rp    = pop ? rp + 1'b1 : rp;
        next_level = level + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            next_wp    = '0;
            next_rp    = '0;
            next_level = '0;
        end
    end

    // state registers; storage has no reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp    <= '0;
            rp    <= '0;
            level <= '0;
        end
        else if (ce)
        begin
            wp    <= next_wp;
            rp    <= next_rp;
            level <= next_level;
            if (push && !flush)
                mem[wp] <= in_data;
        end
    end

    // level never passes the depth; push is held off when full
    property p_no_overflow;
        @(posedge clk) disable iff (rst) level <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo level above depth");
endmodule : umtc_fifo

// ### hdl/umtc_top.sv
// usb master transfer control: register file, two channels, fifo
`timescale 1ns/1ns
module umtc_top
    import umtc_pkg::*;
(
    input  wire logic                     SYS_CLK,     // 100 mhz clock
    input  wire logic                     RST,         // sync reset, high
    input  wire logic                     CE,          // clock enable
    input  wire logic                     PSEL,        // apb select
    input  wire logic                     PENABLE,     // apb access phase
    input  wire logic                     PWRITE,      // apb direction
    input  wire logic [11:0]              PADDR,       // apb byte address
    input  wire logic [umtc_pkg::DATA_W-1:0] PWDATA,   // apb write data
    output logic      [umtc_pkg::DATA_W-1:0] PRDATA,   // apb read data
    output logic                          PREADY,      // apb ready
    output logic                          PSLVERR,     // apb error
    input  wire logic [umtc_pkg::DATA_W-1:0] USB_WDATA, // data from usb core
    input  wire logic                     USB_WVALID,  // usb word valid
    output logic                          USB_WREADY,  // write channel takes word
    output logic [umtc_pkg::DATA_W-1:0]   BUS_WDATA,   // data toward memory
    output logic                          BUS_WVALID,  // memory word valid
    input  wire logic                     BUS_WREADY,  // memory accepts word
    output logic                          USB_RVALID,  // read word to usb core
    output logic                          BURST_INCR   // burst type select
);
    logic                 wrun, rrun, winit, rinit, burst;
    logic [3:0]           wicnt, ricnt;
    logic [CNT_W-1:0]     wcount, rcount, wleft, rleft;
    logic                 next_wrun, next_rrun, next_winit, next_rinit, next_burst;
    logic [3:0]           next_wicnt, next_ricnt;
    logic [CNT_W-1:0]     next_wcount, next_rcount, next_wleft, next_rleft;
    logic [DATA_W-1:0]    next_prdata;
    logic                 next_pready, next_pslverr;
    logic                 wr_acc, rd_acc, fifo_in_ready, fifo_out_valid, fifo_flush;
    logic [DATA_W-1:0]    fifo_data;
    logic [LVL_W-1:0]     fifo_level;
    logic                 fire_w, fire_r;
    logic                 w_stop, w_init, r_stop, r_init;
    logic                 out_load, next_bus_wvalid, next_usb_wready;
    logic [LVL_W-1:0]     level_after;
    logic [DATA_W-1:0]    next_bus_wdata;

    // a write or read is taken in the access phase; answer is one cycle later
    assign wr_acc = PSEL & PENABLE & PWRITE & ~PREADY;
    assign rd_acc = PSEL & PENABLE & ~PWRITE & ~PREADY;
    assign w_stop = wr_acc & (PADDR == CTRL_ADDR) & PWDATA[BIT_WSTOP];
    assign w_init = wr_acc & (PADDR == CTRL_ADDR) & PWDATA[BIT_WINIT];
    assign r_stop = wr_acc & (PADDR == CTRL_ADDR) & PWDATA[BIT_RSTOP];
    assign r_init = wr_acc & (PADDR == CTRL_ADDR) & PWDATA[BIT_RINIT];
    // write channel takes a word exactly when the usb core sees the handshake
    assign fire_w = USB_WVALID & USB_WREADY;
    // read channel pushes one word per cycle to the usb core
    assign fire_r = rrun & ~rinit;
    // flush only our own fifo, endpoint fifos stay
    assign fifo_flush = winit & (wicnt == 4'h1);
    // output stage refills from the fifo when empty or being taken
    assign out_load = fifo_out_valid & (~BUS_WVALID | BUS_WREADY);
    assign next_bus_wvalid = ~fifo_flush & (out_load | (BUS_WVALID & ~BUS_WREADY));
    assign next_bus_wdata  = out_load ? fifo_data : BUS_WDATA;
    // ready is registered, so it must promise room one cycle ahead
    assign level_after = fifo_flush ? '0 : fifo_level + LVL_W'(fire_w) - LVL_W'(out_load);
    assign next_usb_wready = next_wrun & ~next_winit & (level_after != LVL_W'(FIFO_DEPTH));

    umtc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(LVL_W-1)) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RST),
        .ce        (CE),
        .flush     (fifo_flush),
        .in_data   (USB_WDATA),
        .in_valid  (fire_w),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_out_valid),
        .out_ready (out_load),
        .level     (fifo_level)
    );

    // control next-state; hardware clears beat software sets
    always_comb
    begin
        next_wrun   = wrun;
        next_rrun   = rrun;
        next_winit  = winit;
        next_rinit  = rinit;
        next_wicnt  = wicnt;
        next_ricnt  = ricnt;
        next_burst  = burst;
        next_wcount = wcount;
        next_rcount = rcount;
        next_wleft  = wleft;
        next_rleft  = rleft;
        // set only by a one, zero never stops
        if (wr_acc && PADDR == CTRL_ADDR && PWDATA[BIT_WRUN] && !winit)
        begin
            next_wrun  = 1'b1;
            next_wleft = wcount;
        end
        // set only by a one, zero never stops
        if (wr_acc && PADDR == CTRL_ADDR && PWDATA[BIT_RRUN] && !rinit)
        begin
            next_rrun  = 1'b1;
            next_rleft = rcount;
        end
        if (wr_acc && PADDR == CTRL_ADDR)
            next_burst = PWDATA[BIT_BURST];
        if (wr_acc && PADDR == WCOUNT_ADDR)
            next_wcount = PWDATA[CNT_W-1:0];
        if (wr_acc && PADDR == RCOUNT_ADDR)
            next_rcount = PWDATA[CNT_W-1:0];
        // self clear at end of write transfer
        if (fire_w)
        begin
            next_wleft = wleft - 1'b1;
            if (wleft <= 16'h1)
                next_wrun = 1'b0;
        end
        // self clear at end of read transfer
        if (fire_r)
        begin
            next_rleft = rleft - 1'b1;
            if (rleft <= 16'h1)
                next_rrun = 1'b0;
        end
        if (w_stop)
            next_wrun = 1'b0;
        if (r_stop)
            next_rrun = 1'b0;
        if (w_init)
        begin
            next_winit = 1'b1;
            next_wicnt = INIT_CYCLES;
            next_wrun  = 1'b0;
            next_wleft = '0;
        end
        else if (winit)
        begin
            next_wicnt = wicnt - 1'b1;
            if (wicnt == 4'h1)
                next_winit = 1'b0;
        end
        if (r_init)
        begin
            next_rinit = 1'b1;
            next_ricnt = INIT_CYCLES;
            next_rrun  = 1'b0;
            next_rleft = '0;
        end
        else if (rinit)
        begin
            next_ricnt = ricnt - 1'b1;
            if (ricnt == 4'h1)
                next_rinit = 1'b0;
        end
    end

    // apb answer; unmapped addresses read zero and flag an error
    always_comb
    begin
        next_prdata  = ZERO_WORD;
        next_pslverr = 1'b0;
        next_pready  = PSEL & PENABLE & ~PREADY;
        if (PADDR == CTRL_ADDR)
        begin
            next_prdata[BIT_WRUN]  = wrun;
            next_prdata[BIT_WINIT] = winit;
            next_prdata[BIT_RRUN]  = rrun;
            next_prdata[BIT_RINIT] = rinit;
            next_prdata[BIT_BURST] = burst;
        end
        else if (PADDR == WCOUNT_ADDR)
            next_prdata[CNT_W-1:0] = wcount;
        else if (PADDR == RCOUNT_ADDR)
            next_prdata[CNT_W-1:0] = rcount;
        else if (PADDR == STATUS_ADDR)
            next_prdata[LVL_W-1:0] = fifo_level + LVL_W'(BUS_WVALID); // fifo plus output stage
        else
            next_pslverr = PSEL & PENABLE;
        if (!rd_acc)
            next_prdata = ZERO_WORD;
    end

    // registers
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            wrun <= 1'b0; rrun <= 1'b0; winit <= 1'b0; rinit <= 1'b0;
            wicnt <= '0; ricnt <= '0; burst <= 1'b0;
            wcount <= '0; rcount <= '0; wleft <= '0; rleft <= '0;
            PRDATA <= ZERO_WORD; PREADY <= 1'b0; PSLVERR <= 1'b0;
            USB_WREADY <= 1'b0; BUS_WDATA <= ZERO_WORD; BUS_WVALID <= 1'b0;
            USB_RVALID <= 1'b0; BURST_INCR <= 1'b0;
        end
        else if (CE)
        begin
            wrun <= next_wrun; rrun <= next_rrun;
            winit <= next_winit; rinit <= next_rinit;
            wicnt <= next_wicnt; ricnt <= next_ricnt; burst <= next_burst;
            wcount <= next_wcount; rcount <= next_rcount;
            wleft <= next_wleft; rleft <= next_rleft;
            PRDATA <= next_prdata; PREADY <= next_pready;
            PSLVERR <= next_pslverr & next_pready;
            // registered handshakes on both stream sides
            USB_WREADY <= next_usb_wready;
            BUS_WDATA <= next_bus_wdata;
            BUS_WVALID <= next_bus_wvalid;
            USB_RVALID <= fire_r;
            BURST_INCR <= next_burst;
        end
    end

    property p_wstop;
        @(posedge SYS_CLK) disable iff (RST) CE && w_stop |=> !wrun;
    endproperty
    a_wstop: assert property (p_wstop) else $error("write stop left run set");
    property p_rstop;
        @(posedge SYS_CLK) disable iff (RST) CE && r_stop |=> !rrun;
    endproperty
    a_rstop: assert property (p_rstop) else $error("read stop left run set");
    // init lasts four cycles then clears
    property p_winit;
        @(posedge SYS_CLK) disable iff (RST)
            CE && w_init && !winit ##1 CE [*4] |=> !winit;
    endproperty
    a_winit: assert property (p_winit) else $error("write init stuck");
    property p_rinit;
        @(posedge SYS_CLK) disable iff (RST)
            CE && r_init && !rinit ##1 CE [*4] |=> !rinit;
    endproperty
    a_rinit: assert property (p_rinit) else $error("read init stuck");
    property p_wzero;
        @(posedge SYS_CLK) disable iff (RST)
            CE && wrun && wr_acc && PADDR == CTRL_ADDR && PWDATA[3:0] == 4'h0 && !fire_w
            |=> wrun;
    endproperty
    a_wzero: assert property (p_wzero) else $error("zero stopped write");
    // zero write never clears read run
    property p_rzero;
        @(posedge SYS_CLK) disable iff (RST)
            CE && rrun && rleft > 16'h1 && wr_acc && PADDR == CTRL_ADDR
            && PWDATA[6:4] == 3'h0 |=> rrun;
    endproperty
    a_rzero: assert property (p_rzero) else $error("zero stopped read");
    // zero stop/init bits leave init idle
    property p_noop;
        @(posedge SYS_CLK) disable iff (RST) CE && !winit && !w_init |=> !winit;
    endproperty
    a_noop: assert property (p_noop) else $error("init without request");
    // no words pulled from the usb core while init runs
    property p_flush;
        @(posedge SYS_CLK) disable iff (RST) winit |-> !USB_WREADY && !fire_w;
    endproperty
    a_flush: assert property (p_flush) else $error("usb words taken during init");
    // ready toward the usb core only with room in the fifo
    property p_room;
        @(posedge SYS_CLK) disable iff (RST) USB_WREADY |-> fifo_in_ready;
    endproperty
    a_room: assert property (p_room) else $error("usb ready without fifo room");
    c_wdone: cover property (@(posedge SYS_CLK) wrun ##1 !wrun);
    c_rdone: cover property (@(posedge SYS_CLK) rrun ##1 !rrun);
    c_winit: cover property (@(posedge SYS_CLK) winit ##1 !winit);
endmodule : umtc_top

// ### tb/umtc_partner.sv
// partner model: usb core word source and memory-side sink
`timescale 1ns/1ns
module umtc_partner (
    input  wire logic        clk,        // clock
    input  wire logic        rst,        // sync reset, high
    input  wire logic        src_en,     // offer new words
    input  wire logic        sink_en,    // accept words
    output logic      [31:0] usb_wdata,  // word to block
    output logic             usb_wvalid, // word valid
    input  wire logic        usb_wready, // block takes word
    input  wire logic [31:0] bus_wdata,  // word from block
    input  wire logic        bus_wvalid, // block word valid
    output logic             bus_wready, // sink ready
    output int               n_pop,      // words taken
    output logic      [31:0] last_pop    // last word taken
);
    logic [31:0] seq;
    // idle data is the inverse, so a stale word never passes for a fresh one
    assign usb_wdata  = usb_wvalid ? 32'ha5000000 + seq : ~(32'ha5000000 + seq);
    assign bus_wready = sink_en;
    // an offer is held until taken, even if src_en drops meanwhile
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seq        <= 32'h0;
            usb_wvalid <= 1'b0;
            n_pop      <= 0;
            last_pop   <= 32'h0;
        end
        else
        begin
            if (usb_wvalid && usb_wready)
                seq <= seq + 32'h1;
            usb_wvalid <= (usb_wvalid && !usb_wready) || src_en;
            if (bus_wvalid && bus_wready)
            begin
                n_pop    <= n_pop + 1;
                last_pop <= bus_wdata;
            end
        end
    end
endmodule : umtc_partner

// ### tb/tb.sv
// self-checking testbench for the usb master transfer control block
`timescale 1ns/1ns
module tb;
    import umtc_pkg::*;
    logic clk, rst, psel, pen, pwr, src_en, sink_en, err, pready, pslverr;
    logic usb_wvalid, usb_wready, bus_wvalid, bus_wready, usb_rvalid, burst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, usb_wdata, bus_wdata, rd, last_pop;
    int n_fail, check_count, n_pop, n_rv, base;

    umtc_top umtc_top_inst (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .USB_WDATA(usb_wdata), .USB_WVALID(usb_wvalid),
        .USB_WREADY(usb_wready), .BUS_WDATA(bus_wdata), .BUS_WVALID(bus_wvalid),
        .BUS_WREADY(bus_wready), .USB_RVALID(usb_rvalid), .BURST_INCR(burst));
    umtc_partner umtc_partner_inst (.clk(clk), .rst(rst), .src_en(src_en),
        .sink_en(sink_en), .usb_wdata(usb_wdata), .usb_wvalid(usb_wvalid),
        .usb_wready(usb_wready), .bus_wdata(bus_wdata), .bus_wvalid(bus_wvalid),
        .bus_wready(bus_wready), .n_pop(n_pop), .last_pop(last_pop));

    // read word pulses, sampled before this edge's updates land
    always @(posedge clk)
        if (rst) n_rv <= 0; else if (usb_rvalid) n_rv <= n_rv + 1;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // answer and read data are taken at the edge that shows pready high
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin n_fail++; stop_test(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rdr

    // bounded poll until the masked field reads v
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int i;
        for (i = 0; i < 100; i++)
        begin
            rdr(a);
            if ((rd & m) === v) break;
        end
        if (i == 100) begin n_fail++; stop_test(); end
    endtask : poll

    task automatic t_regs();
        rdr(CTRL_ADDR);
        chk("ctrl reset", rd, 32'h0);
        rdr(12'h010);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wr(CTRL_ADDR, 32'h100);
        rdr(CTRL_ADDR);
        chk("burst bit", rd, 32'h100);
        chk("burst pin", {31'h0, burst}, 32'h1);
        wr(CTRL_ADDR, 32'h0);
        chk("burst pin off", {31'h0, burst}, 32'h0);
    endtask : t_regs

    task automatic t_wrun();
        sink_en <= 1'b1;
        wr(WCOUNT_ADDR, 32'h3);
        wr(CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h0);
        rdr(CTRL_ADDR);
        chk("wrun held", {31'h0, rd[BIT_WRUN]}, 32'h1);
        src_en <= 1'b1;
        poll(CTRL_ADDR, 32'h1, 32'h0);
        src_en <= 1'b0;
        poll(STATUS_ADDR, 32'h1f, 32'h0);
        chk("words moved", n_pop, 32'h3);
        chk("last word", last_pop, 32'ha5000002);
    endtask : t_wrun

    task automatic t_wstop();
        sink_en <= 1'b0;
        wr(WCOUNT_ADDR, 32'ha);
        wr(CTRL_ADDR, 32'h1);
        wr(CTRL_ADDR, 32'h2);
        // abort done once run reads 0
        rdr(CTRL_ADDR);
        chk("wrun after stop", {31'h0, rd[BIT_WRUN]}, 32'h0);
        chk("stop reads zero", {31'h0, rd[BIT_WSTOP]}, 32'h0);
        rdr(STATUS_ADDR);
        chk("level held", rd & 32'h1f, 32'h1);
        // init only with the channel stopped
        wr(CTRL_ADDR, 32'h4);
        // no new transfer until init reads 0
        poll(CTRL_ADDR, 32'h4, 32'h0);
        rdr(STATUS_ADDR);
        chk("level after init", rd & 32'h1f, 32'h0);
    endtask : t_wstop

    task automatic t_fill();
        base = n_pop;
        src_en <= 1'b1;
        wr(WCOUNT_ADDR, 32'h14);
        wr(CTRL_ADDR, 32'h1);
        // sixteen words in the fifo plus one in the output stage
        poll(STATUS_ADDR, 32'h1f, 32'h11);
        chk("wready when full", {31'h0, usb_wready}, 32'h0);
        rdr(CTRL_ADDR);
        chk("wrun while full", {31'h0, rd[BIT_WRUN]}, 32'h1);
        sink_en <= 1'b1;
        poll(CTRL_ADDR, 32'h1, 32'h0);
        src_en <= 1'b0;
        poll(STATUS_ADDR, 32'h1f, 32'h0);
        chk("words drained", n_pop - base, 32'h14);
    endtask : t_fill

    task automatic t_read();
        base = n_rv;
        wr(RCOUNT_ADDR, 32'h5);
        wr(CTRL_ADDR, 32'h10);
        poll(CTRL_ADDR, 32'h10, 32'h0);
        chk("read words", n_rv - base, 32'h5);
        wr(RCOUNT_ADDR, 32'h100);
        wr(CTRL_ADDR, 32'h10);
        wr(CTRL_ADDR, 32'h0);
        rdr(CTRL_ADDR);
        chk("rrun held", {31'h0, rd[BIT_RRUN]}, 32'h1);
        wr(CTRL_ADDR, 32'h20);
        rdr(CTRL_ADDR);
        chk("rrun after stop", {31'h0, rd[BIT_RRUN]}, 32'h0);
        base = n_rv;
        repeat (8) @(posedge clk);
        chk("no read words", n_rv - base, 32'h0);
        wr(CTRL_ADDR, 32'h40);
        poll(CTRL_ADDR, 32'h40, 32'h0);
    endtask : t_read

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog cuts a hang short
    initial
    begin
        repeat (50000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial
    begin
        {rst, psel, pen, pwr, src_en, sink_en} = 6'h20;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wrun();
        t_wstop();
        t_fill();
        t_read();
        stop_test();
    end
endmodule : tb
